// >>> core/two_wire_cfg.svh
// Register offsets, status bit positions and reset values.
`ifndef TWO_WIRE_CFG_SVH
`define TWO_WIRE_CFG_SVH
`define OFS_STATUS     8'h00
`define OFS_IRQ_SET    8'h04
`define OFS_IRQ_CLEAR  8'h08
`define OFS_IRQ_MASK   8'h0c
`define B_XFER_DONE    0
`define B_RX_READY     1
`define B_TX_EMPTY     2
`define B_SLV_DIR      3
`define B_SLV_ACC      4
`define B_GEN_CALL     5
`define B_OVERRUN      6
`define B_NOT_ACK      8
`define B_ARB_LOST     9
`define B_CLK_WAIT     10
`define B_END_SLV      11
`define B_END_RX       12
`define B_END_TX       13
`define B_RX_FULL      14
`define B_TXB_EMPTY    15
`define STATUS_RST     16'hf009
`define STATUS_FLOPS   16'h3b7f
`define READ_CLEARS    16'h0b60
`define IRQ_USED       16'hff77
`define IRQ_MASK_RST   16'h0000
`endif

// >>> core/two_wire_pkg.sv
// Types shared by the two-wire status and interrupt block.
package two_wire_pkg;
  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_MASTER = 2'h1,
    MODE_SLAVE  = 2'h3
  } op_mode_t;
  typedef struct packed {
    logic thr_write;
    logic rhr_read;
    logic rhr_load;
    logic ms_enable;
  } host_ev_t;
  typedef struct packed {
    logic byte_to_shift;
    logic nack;
    logic frame_start;
    logic frame_done;
    logic arb_lost;
  } mst_ev_t;
  typedef struct packed {
    logic addr_match;
    logic addr_read;
    logic gen_call;
    logic byte_done;
    logic nack;
    logic char_due;
  } slv_ev_t;
  typedef struct packed {
    logic rx_zero;
    logic rx_next_zero;
    logic tx_zero;
    logic tx_next_zero;
    logic rx_write;
    logic tx_write;
  } dma_t;
endpackage

// >>> core/two_wire_status_irq.sv
// Status flags, interrupt mask and APB slave of the two-wire controller.
`timescale 1ns/1ps
`include "two_wire_cfg.svh"

module two_wire_status_irq #(
  parameter int ADDR_W = 8
) (
  // APB slave
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Mode and events from the protocol engine
  input  wire two_wire_pkg::op_mode_t mode,
  input  wire two_wire_pkg::host_ev_t host_ev,
  input  wire two_wire_pkg::mst_ev_t  mst_ev,
  input  wire two_wire_pkg::slv_ev_t  slv_ev,
  input  wire two_wire_pkg::dma_t     dma,
  // Two-wire bus pins
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       scl_o,
  output logic                       scl_oe_n,
  // Engine controls and interrupt
  output logic                       ack_en,
  output logic                       tx_halt,
  output logic                       irq
);
  import two_wire_pkg::*;

  localparam logic [15:0] FLOPS = `STATUS_FLOPS;
  localparam logic [15:0] RSTV  = `STATUS_RST;

  if (ADDR_W < 8) begin : g_bad_width
    $error("ADDR_W must be at least 8");
  end

  logic [15:0] sr_q;
  logic [15:0] imr;
  logic [15:0] set_v;
  logic [15:0] clr_v;
  logic [15:0] comb_v;
  logic        scl_s1, scl_s2, scl_s3;
  logic        sda_s1, sda_s2, sda_s3;

  // Pins are asynchronous to pclk, so two stages come before any use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
    end
  end

  wire scl_high  = scl_s2 & scl_s3;
  wire bus_start = scl_high & sda_s3 & ~sda_s2;
  wire bus_stop  = scl_high & ~sda_s3 & sda_s2;
  wire is_m      = (mode == MODE_MASTER);
  wire is_s      = (mode == MODE_SLAVE);

  // APB decode.
  wire [7:0] ofs      = paddr[7:0];
  wire       hit_sr   = (ofs == `OFS_STATUS);
  wire       hit_set  = (ofs == `OFS_IRQ_SET);
  wire       hit_clr  = (ofs == `OFS_IRQ_CLEAR);
  wire       hit_mask = (ofs == `OFS_IRQ_MASK);
  wire       hit_any  = hit_sr | hit_set | hit_clr | hit_mask;
  wire       setup    = psel & ~penable;
  wire       access   = psel & penable;
  wire       wr_set   = access & pwrite & hit_set;
  wire       wr_clr   = access & pwrite & hit_clr;
  wire       rd_sr    = access & ~pwrite & hit_sr;
  wire [31:0] rd_mux  = hit_sr   ? {16'h0000, sr_q} :
                        hit_mask ? {16'h0000, imr}  : 32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = access & ~hit_any;
  assign scl_o   = 1'b0;

  // Read data is captured at setup, so a read clears only the flags it
  // returned; a flag set after the capture survives the read.
  wire [15:0] rd_clr_raw = rd_sr ? (prdata[15:0] & `READ_CLEARS) : 16'h0000;
  wire [15:0] rd_clr     = {rd_clr_raw[15:7],
                            rd_clr_raw[6] & prdata[`B_XFER_DONE],
                            rd_clr_raw[5:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= rd_mux;
    end
  end

  // Mask register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imr <= `IRQ_MASK_RST;
    end else if (wr_set) begin
      imr <= imr | (pwdata[15:0] & `IRQ_USED);
    end else if (wr_clr) begin
      imr <= imr & ~pwdata[15:0];
    end
  end

  // Clock stretch while the slave waits on software.
  wire need_sw = sr_q[`B_SLV_DIR] ? sr_q[`B_TX_EMPTY] : sr_q[`B_RX_READY];
  wire halted  = sr_q[`B_TX_EMPTY] & sr_q[`B_NOT_ACK];
  wire stretch = is_s & sr_q[`B_SLV_ACC] & slv_ev.char_due & need_sw
                 & ~(sr_q[`B_SLV_DIR] & halted);

  // Hardware set terms.
  assign set_v[`B_XFER_DONE] = (is_m & (mst_ev.frame_done
                               | mst_ev.arb_lost | mst_ev.nack))
                               | (is_s & bus_stop);
  assign set_v[`B_RX_READY]  = host_ev.rhr_load;
  assign set_v[`B_TX_EMPTY]  = (is_m & (mst_ev.byte_to_shift
                               | mst_ev.nack))
                               | host_ev.ms_enable
                               | (is_s & slv_ev.byte_done);
  assign set_v[`B_SLV_DIR]   = is_s & slv_ev.addr_match
                               & slv_ev.addr_read;
  assign set_v[`B_SLV_ACC]   = is_s & slv_ev.addr_match;
  assign set_v[`B_GEN_CALL]  = is_s & slv_ev.gen_call;
  assign set_v[`B_OVERRUN]   = is_m & host_ev.rhr_load
                               & sr_q[`B_RX_READY];
  assign set_v[7]            = 1'b0;
  assign set_v[`B_NOT_ACK]   = (is_m & mst_ev.nack)
                               | (is_s & slv_ev.nack
                               & sr_q[`B_SLV_DIR]);
  assign set_v[`B_ARB_LOST]  = is_m & mst_ev.arb_lost;
  assign set_v[`B_CLK_WAIT]  = 1'b0;
  assign set_v[`B_END_SLV]   = sr_q[`B_SLV_ACC] & clr_v[`B_SLV_ACC]
                               & ~set_v[`B_SLV_ACC];
  assign set_v[`B_END_RX]    = is_m & dma.rx_zero;
  assign set_v[`B_END_TX]    = is_m & dma.tx_zero;
  assign set_v[15:14]        = 2'h0;

  // Hardware clear terms, merged with read-to-clear.
  wire [15:0] hw_clr;
  assign hw_clr[`B_XFER_DONE] = (is_m & mst_ev.frame_start)
                                | (is_s & bus_start);
  assign hw_clr[`B_RX_READY]  = host_ev.rhr_read;
  assign hw_clr[`B_TX_EMPTY]  = host_ev.thr_write;
  assign hw_clr[`B_SLV_DIR]   = is_s & slv_ev.addr_match
                                & ~slv_ev.addr_read;
  assign hw_clr[`B_SLV_ACC]   = slv_ev.nack | bus_stop;
  assign hw_clr[11:5]         = 7'h00;
  assign hw_clr[`B_END_RX]    = dma.rx_write;
  assign hw_clr[`B_END_TX]    = dma.tx_write;
  assign hw_clr[15:14]        = 2'h0;
  assign clr_v = hw_clr | rd_clr;

  // Level flags that follow their sources directly.
  assign comb_v = {is_m & dma.tx_zero & dma.tx_next_zero,
                   is_m & dma.rx_zero & dma.rx_next_zero,
                   3'h0, stretch, 10'h000};

  // One sticky flop per flag set in STATUS_FLOPS, the others take comb_v; a set in the clearing cycle wins.
  for (genvar i = 0; i < 16; i++) begin : g_flag
    if (FLOPS[i]) begin : g_ff
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sr_q[i] <= RSTV[i];
        end else begin
          sr_q[i] <= set_v[i] | (sr_q[i] & ~clr_v[i]);
        end
      end
    end else begin : g_lvl
      assign sr_q[i] = comb_v[i];
    end
  end

  // Registered controls toward the pins and the engine, and the interrupt output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe_n <= 1'b1;
      ack_en   <= 1'b0;
      tx_halt  <= 1'b0;
      irq      <= 1'b0;
    end else begin
      scl_oe_n <= ~stretch;
      ack_en   <= is_s & sr_q[`B_SLV_ACC] & ~sr_q[`B_SLV_DIR];
      tx_halt  <= is_s & halted;
      irq      <= |(sr_q & imr);
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TX_WRITE: assert property (
    host_ev.thr_write && !set_v[`B_TX_EMPTY] |=> !sr_q[`B_TX_EMPTY])
    else $error("holding-empty not cleared by data write");
  AST_MS_ENABLE: assert property (
    host_ev.ms_enable |=> sr_q[`B_TX_EMPTY])
    else $error("holding-empty not set by master enable");
  AST_SLV_HOLD: assert property (
    is_s && !sr_q[`B_TX_EMPTY] && !slv_ev.byte_done && !host_ev.ms_enable
    |=> !sr_q[`B_TX_EMPTY])
    else $error("slave holding-empty rose without a sent byte");
  AST_HALT: assert property (
    is_s && sr_q[`B_TX_EMPTY] && sr_q[`B_NOT_ACK] |=> tx_halt)
    else $error("slave sending not halted");
  AST_DIR: assert property (
    is_s && slv_ev.addr_match
    |=> sr_q[`B_SLV_DIR] == $past(slv_ev.addr_read))
    else $error("slave direction wrong");
  AST_ACC_END: assert property (
    is_s && bus_stop && !slv_ev.addr_match |=> !sr_q[`B_SLV_ACC])
    else $error("slave access not cleared by stop");
  AST_GEN_CALL: assert property (
    is_s && slv_ev.gen_call |=> sr_q[`B_GEN_CALL])
    else $error("general call not flagged");
  AST_OVERRUN: assert property (
    is_m && host_ev.rhr_load && sr_q[`B_RX_READY] |=> sr_q[`B_OVERRUN])
    else $error("overrun not flagged");
  AST_M_NACK: assert property (
    is_m && mst_ev.nack
    |=> sr_q[`B_NOT_ACK] && sr_q[`B_XFER_DONE] && sr_q[`B_TX_EMPTY])
    else $error("master not-ack flags incomplete");
  AST_ACK: assert property (
    is_s && sr_q[`B_SLV_ACC] && !sr_q[`B_SLV_DIR] |=> ack_en)
    else $error("slave write byte not acknowledged");
  AST_ARB: assert property (
    is_m && mst_ev.arb_lost |=> sr_q[`B_ARB_LOST] && sr_q[`B_XFER_DONE])
    else $error("arbitration loss not flagged");
  AST_STRETCH: assert property (
    stretch |=> !scl_oe_n)
    else $error("clock not stretched");
  AST_END_SLV: assert property (
    $fell(sr_q[`B_SLV_ACC]) |-> sr_q[`B_END_SLV])
    else $error("end of slave access missing");
  AST_IRQ_SET: assert property (
    wr_set |=> (imr & ($past(pwdata[15:0]) & `IRQ_USED))
               == ($past(pwdata[15:0]) & `IRQ_USED))
    else $error("enable write lost");
  AST_IRQ_CLR: assert property (
    wr_clr |=> (imr & $past(pwdata[15:0])) == 16'h0000)
    else $error("disable write lost");
  AST_IRQ_OUT: assert property (
    ##1 irq == $past(|(sr_q & imr)))
    else $error("interrupt output wrong");
  AST_DONE_LOW: assert property (
    is_m && mst_ev.frame_start && !set_v[`B_XFER_DONE]
    |=> !sr_q[`B_XFER_DONE])
    else $error("transfer done high in frame");

  // A read clears only the flags it returned, so read checks use prdata.
  AST_CLK_WAIT: assert property (
    stretch |-> sr_q[`B_CLK_WAIT])
    else $error("clock wait flag missing");
  AST_STRETCH_OFF: assert property (
    !stretch |=> scl_oe_n)
    else $error("clock held without a wait");
  AST_HALT_OFF: assert property (
    !(is_s && sr_q[`B_TX_EMPTY] && sr_q[`B_NOT_ACK]) |=> !tx_halt)
    else $error("slave sending halted without cause");
  AST_TX_SHIFT: assert property (
    is_m && mst_ev.byte_to_shift |=> sr_q[`B_TX_EMPTY])
    else $error("holding-empty not set by shift");
  AST_SLV_SENT: assert property (
    is_s && slv_ev.byte_done |=> sr_q[`B_TX_EMPTY])
    else $error("slave holding-empty not set after byte");
  AST_ACC_SET: assert property (
    is_s && slv_ev.addr_match |=> sr_q[`B_SLV_ACC])
    else $error("slave access not set on match");
  AST_ACC_NACK: assert property (
    slv_ev.nack && !set_v[`B_SLV_ACC] |=> !sr_q[`B_SLV_ACC])
    else $error("slave access not cleared by not-ack");
  AST_GC_CLEAR: assert property (
    rd_sr && prdata[`B_GEN_CALL] && !set_v[`B_GEN_CALL]
    |=> !sr_q[`B_GEN_CALL])
    else $error("general call not cleared by read");
  AST_OVR_KEEP: assert property (
    rd_sr && !prdata[`B_XFER_DONE] && sr_q[`B_OVERRUN]
    |=> sr_q[`B_OVERRUN])
    else $error("overrun cleared without transfer done");
  AST_OVR_CLEAR: assert property (
    rd_sr && prdata[`B_XFER_DONE] && prdata[`B_OVERRUN]
    && !set_v[`B_OVERRUN] |=> !sr_q[`B_OVERRUN])
    else $error("overrun not cleared by read");
  AST_NACK_CLEAR: assert property (
    rd_sr && prdata[`B_NOT_ACK] && !set_v[`B_NOT_ACK]
    |=> !sr_q[`B_NOT_ACK])
    else $error("not-ack not cleared by read");
  AST_SLV_NACK: assert property (
    is_s && slv_ev.nack && sr_q[`B_SLV_DIR] |=> sr_q[`B_NOT_ACK])
    else $error("slave read not-ack not flagged");
  AST_ACK_OFF: assert property (
    !(is_s && sr_q[`B_SLV_ACC] && !sr_q[`B_SLV_DIR]) |=> !ack_en)
    else $error("acknowledge enabled outside slave write");
  AST_ARB_CLEAR: assert property (
    rd_sr && prdata[`B_ARB_LOST] && !set_v[`B_ARB_LOST]
    |=> !sr_q[`B_ARB_LOST])
    else $error("arbitration loss not cleared by read");
  AST_END_SLV_CLR: assert property (
    rd_sr && prdata[`B_END_SLV] && !set_v[`B_END_SLV]
    |=> !sr_q[`B_END_SLV])
    else $error("end of slave access not cleared by read");
  AST_END_RX: assert property (
    is_m && dma.rx_zero |=> sr_q[`B_END_RX])
    else $error("end of receive buffer not set");
  AST_END_RX_CLR: assert property (
    dma.rx_write && !set_v[`B_END_RX] |=> !sr_q[`B_END_RX])
    else $error("end of receive buffer not cleared");
  AST_END_TX: assert property (
    is_m && dma.tx_zero |=> sr_q[`B_END_TX])
    else $error("end of transmit buffer not set");
  AST_END_TX_CLR: assert property (
    dma.tx_write && !set_v[`B_END_TX] |=> !sr_q[`B_END_TX])
    else $error("end of transmit buffer not cleared");
  AST_RX_FULL: assert property (
    sr_q[`B_RX_FULL] == (is_m && dma.rx_zero && dma.rx_next_zero))
    else $error("receive buffer full wrong");
  AST_TXB_EMPTY: assert property (
    sr_q[`B_TXB_EMPTY] == (is_m && dma.tx_zero && dma.tx_next_zero))
    else $error("transmit buffer empty wrong");
  AST_MASK_GAP: assert property (
    !imr[3] && !imr[7])
    else $error("unused mask bit set");
  AST_IRQ_KEEP: assert property (
    wr_set |=> ($past(imr) & ~imr) == 16'h0000)
    else $error("enable write dropped a source");
  AST_IRQ_NOGAIN: assert property (
    wr_clr |=> (imr & ~$past(imr)) == 16'h0000)
    else $error("disable write enabled a source");
  AST_IRQ_MASKED: assert property (
    (sr_q & imr) == 16'h0000 |=> !irq)
    else $error("interrupt without a masked flag");
  AST_DONE_SET: assert property (
    is_m && mst_ev.frame_done |=> sr_q[`B_XFER_DONE])
    else $error("transfer done not set");

  // Main scenarios that the bench is expected to reach.
  COV_GEN_CALL: cover property (is_s && slv_ev.gen_call ##[1:10] rd_sr);
  COV_HALT: cover property (is_s && tx_halt);
  COV_OVR_CLEAR: cover property (rd_sr && prdata[`B_OVERRUN]
    && prdata[`B_XFER_DONE]);
  COV_STRETCH: cover property (stretch [*3]);
  COV_ARB: cover property (is_m && mst_ev.arb_lost ##[1:20] irq);
endmodule

// >>> testbench/two_wire_far.sv
// Remote two-wire party that frames transfers with START and STOP.
`timescale 1ns/1ps
module two_wire_far (
  // Device pin control
  input  wire logic scl_oe_n,
  // Bus lines
  output logic      scl_line,
  output logic      sda_line
);
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;
  // Open drain with pull-ups: the clock stands high outside frames.
  assign scl_line = scl_drv & scl_oe_n;
  assign sda_line = sda_drv;
  task automatic start_cond();
    #1 sda_drv = 1'b0;
    #32 scl_drv = 1'b0;
  endtask
  task automatic stop_cond();
    #32 scl_drv = 1'b1;
    // A stretching device keeps the clock low, so wait for the release.
    wait (scl_line === 1'b1);
    #32 sda_drv = 1'b1;
  endtask
endmodule

// >>> testbench/two_wire_status_irq_tb.sv
// Self-checking bench of the two-wire status and interrupt block.
`timescale 1ns/1ps
`include "two_wire_cfg.svh"
module two_wire_status_irq_tb;
  import two_wire_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  op_mode_t    mode = MODE_MASTER;
  host_ev_t    host_ev = '0;
  mst_ev_t     mst_ev = '0;
  slv_ev_t     slv_ev = '0;
  dma_t        dma = 6'b111100;
  logic        scl_line;
  logic        sda_line;
  logic        scl_o;
  logic        scl_oe_n;
  logic        ack_en;
  logic        tx_halt;
  logic        irq;
  logic        due = 1'b0;
  logic [31:0] rdat;
  logic        err;
  int          miscompares = 0;
  int          n_tests = 0;

  two_wire_status_irq uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode(mode),
    .host_ev(host_ev), .mst_ev(mst_ev), .slv_ev(slv_ev), .dma(dma),
    .scl_i(scl_line), .sda_i(sda_line), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .ack_en(ack_en), .tx_halt(tx_halt), .irq(irq));
  two_wire_far far (.scl_oe_n(scl_oe_n), .scl_line(scl_line),
    .sda_line(sda_line));

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  task automatic close_out();
    if (miscompares == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %0t: got %h want %h", $time, s, e);
    end
  endtask

  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic st(input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rdat & m, e);
  endtask

  task automatic ev(input host_ev_t h, input mst_ev_t m,
                    input slv_ev_t s);
    @(posedge pclk);
    host_ev <= h;
    mst_ev <= m;
    slv_ev <= s | slv_ev_t'({5'b0, due});
    @(posedge pclk);
    host_ev <= '0;
    mst_ev <= '0;
    slv_ev <= slv_ev_t'({5'b0, due});
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_regs();
    st(32'hffffffff, 32'h0000f009);
    apb(1'b0, `OFS_IRQ_SET, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    chk(rdat, 32'h0);
    apb(1'b1, `OFS_IRQ_SET, 32'hffffffff);
    apb(1'b0, `OFS_IRQ_MASK, 32'h0);
    chk(rdat, 32'h0000ff77);
    apb(1'b1, `OFS_IRQ_CLEAR, 32'h00000077);
    apb(1'b1, `OFS_IRQ_SET, 32'h0);
    apb(1'b0, `OFS_IRQ_MASK, 32'h0);
    chk(rdat, 32'h0000ff00);
    apb(1'b1, `OFS_IRQ_CLEAR, 32'hffffffff);
    apb(1'b1, `OFS_IRQ_SET, 32'h1);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, `OFS_IRQ_CLEAR, 32'h1);
    repeat (3) @(posedge pclk);
    chk(irq, 1'b0);
  endtask

  task automatic t_master();
    ev(4'b1000, '0, '0);
    st(32'h4, 32'h0);
    ev('0, 5'b10000, '0);
    st(32'h4, 32'h4);
    ev(4'b1000, '0, '0);
    st(32'h4, 32'h0);
    ev(4'b0001, '0, '0);
    st(32'h4, 32'h4);
    ev('0, 5'b00100, '0);
    st(32'h1, 32'h0);
    ev(4'b1000, 5'b01000, '0);
    st(32'h105, 32'h105);
    st(32'h100, 32'h0);
    ev('0, 5'b00100, '0);
    ev(4'b0010, '0, '0);
    ev(4'b0010, '0, '0);
    st(32'h41, 32'h40);
    st(32'h40, 32'h40);
    ev('0, 5'b00010, '0);
    st(32'h41, 32'h41);
    st(32'h40, 32'h0);
    ev('0, 5'b00100, '0);
    apb(1'b1, `OFS_IRQ_SET, 32'h200);
    ev('0, 5'b00001, '0);
    chk(irq, 1'b1);
    st(32'h201, 32'h201);
    st(32'h200, 32'h0);
  endtask

  task automatic t_dma();
    @(posedge pclk);
    dma <= 6'b000011;
    @(posedge pclk);
    dma <= 6'b000000;
    chk(irq, 1'b0);
    st(32'hf000, 32'h0);
    dma <= 6'b101000;
    st(32'hf000, 32'h3000);
    dma <= 6'b111100;
    st(32'hf000, 32'hf000);
  endtask

  task automatic t_slave();
    mode <= MODE_SLAVE;
    far.start_cond();
    repeat (10) @(posedge pclk);
    st(32'h1, 32'h0);
    ev('0, '0, 6'b100000);
    st(32'h18, 32'h10);
    chk(ack_en, 1'b1);
    ev('0, '0, 6'b001000);
    st(32'h20, 32'h20);
    st(32'h20, 32'h0);
    far.stop_cond();
    repeat (10) @(posedge pclk);
    st(32'h810, 32'h800);
    st(32'h800, 32'h0);
    far.start_cond();
    ev('0, '0, 6'b110000);
    st(32'h18, 32'h18);
    due = 1'b1;
    ev('0, '0, '0);
    chk(scl_oe_n, 1'b0);
    chk(scl_o, 1'b0);
    st(32'h400, 32'h400);
    ev(4'b1000, '0, '0);
    chk(scl_oe_n, 1'b1);
    st(32'h4, 32'h0);
    due = 1'b0;
    ev('0, '0, 6'b000100);
    st(32'h4, 32'h4);
    ev('0, '0, 6'b000010);
    // Holding-empty with not-ack: software leaves the holding register.
    chk(tx_halt, 1'b1);
    st(32'h114, 32'h104);
    far.stop_cond();
  endtask

  initial begin
    #100000;
    miscompares++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_master();
    t_dma();
    t_slave();
    close_out();
  end
endmodule
